// *** verilog/smb_device.sv ***
// Device end: bus slave giving a host byte access to an external register file.
// Assumes the host makes SCL; the register file lives outside on clock.
`timescale 1ns/1ns
`include "smb_cfg.svh"
module smb_device
  import smb_pkg::*;
#(
  parameter logic [`TMO_W-1:0] TIMEOUT_CYCLES = `TMO_W'(`TMO_CYCLES)
) (
  input  wire logic       clock,                // system clock
  input  wire logic       arst_n,               // asynchronous reset
  smb_if.dev              bus,                  // bus pins
  input  wire logic       address_strap_enable, // address strap enable pin
  input  wire logic       addr_select_strap,    // address select strap pin
  input  wire logic       bus_timeout_disable,  // disables the SCL low timeout
  input  wire logic       alert_active,         // device has an alert pending
  input  wire logic [7:0] rd_data,              // contents of rd_index register
  output logic      [7:0] rd_index,             // register the pointer selects
  output logic            wr_strobe,            // one-cycle register write
  output logic      [7:0] wr_index,             // register being written
  output logic      [7:0] wr_data               // value being written
);
  // System clock side: straps, timeout and register port.
  logic               en_r, en_nxt, cap_r, cap_nxt;
  logic [6:0]         sel_addr_r, sel_addr_nxt;
  logic [`TMO_W-1:0]  tcnt_r, tcnt_nxt;
  logic               lrst_n_r, lrst_n_nxt;
  logic               ev_q_r, ev_q_nxt, alert_r, alert_nxt;
  logic [7:0]         rd_index_nxt, wr_index_nxt, wr_data_nxt;
  logic               wr_strobe_nxt;
  logic               scl_s, sel_s, ev_s;
  // Link side, rising SCL.
  dev_st_t            st_r, st_nxt;
  logic [3:0]         cnt_r, cnt_nxt;
  logic [6:0]         shf_r, shf_nxt;
  logic               ack_r, ack_nxt, rw_r, rw_nxt;
  logic [1:0]         bidx_r, bidx_nxt;
  logic [7:0]         tx_r, tx_nxt;
  logic               seen_r, seen_nxt, sda_p_r, sda_p_nxt;
  logic [7:0]         ptr_r, ptr_nxt, wdat_r, wdat_nxt;
  logic               ev_tgl_r, ev_tgl_nxt, ev_dat_r, ev_dat_nxt;
  logic               lat_r, lat_nxt;
  logic [6:0]         lat_addr_r, lat_addr_nxt;
  // Link side, falling SCL and rising SDA.
  logic               oe_n_r, oe_n_nxt, stt_tgl_r, stt_tgl_nxt;
  logic               stp_ack_r, stp_ack_nxt, stp_tgl_r, stp_tgl_nxt;
  logic [6:0]         own;
  logic [7:0]         byte8;
  logic               hit_own, hit_ara;

  sync2 u_scl (.clock(clock), .arst_n(arst_n), .d(bus.scl), .q(scl_s));
  sync2 u_sel (.clock(clock), .arst_n(arst_n), .d(addr_select_strap), .q(sel_s));
  sync2 u_ev (.clock(clock), .arst_n(arst_n), .d(ev_tgl_r), .q(ev_s));

  assign bus.sda_o_dev    = 1'b0;
  assign bus.sda_oe_n_dev = oe_n_r;

  // The enable strap is caught once, on the first edge after reset release.
  always_comb begin
    en_nxt        = cap_r ? en_r : address_strap_enable;
    cap_nxt       = 1'b1;
    sel_addr_nxt  = en_r ? `ADDR_DEFAULT : (sel_s ? `ADDR_SEL_HI : `ADDR_SEL_LO);
    alert_nxt     = alert_active;
    // A stalled SCL low resets the link logic, which releases SDA.
    if (scl_s || bus_timeout_disable) begin
      tcnt_nxt = '0;
    end else if (tcnt_r != TIMEOUT_CYCLES) begin
      tcnt_nxt = tcnt_r + `TMO_W'(1);
    end else begin
      tcnt_nxt = tcnt_r;
    end
    lrst_n_nxt    = (tcnt_r != TIMEOUT_CYCLES);
    ev_q_nxt      = ev_s;
    rd_index_nxt  = rd_index;
    wr_strobe_nxt = 1'b0;
    wr_index_nxt  = wr_index;
    wr_data_nxt   = wr_data;
    // Pointer and data are stable for many SCL periods after the toggle.
    if (ev_s != ev_q_r) begin
      rd_index_nxt = ptr_r;
      if (ev_dat_r) begin
        wr_strobe_nxt = 1'b1;
        wr_index_nxt  = ptr_r;
        wr_data_nxt   = wdat_r;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_r       <= 1'b1;
      cap_r      <= 1'b0;
      sel_addr_r <= `ADDR_DEFAULT;
      tcnt_r     <= '0;
      lrst_n_r   <= 1'b0;
      ev_q_r     <= 1'b0;
      alert_r    <= 1'b0;
      rd_index   <= `PTR_RESET;
      wr_strobe  <= 1'b0;
      wr_index   <= `PTR_RESET;
      wr_data    <= 8'h00;
    end else begin
      en_r       <= en_nxt;
      cap_r      <= cap_nxt;
      sel_addr_r <= sel_addr_nxt;
      tcnt_r     <= tcnt_nxt;
      lrst_n_r   <= lrst_n_nxt;
      ev_q_r     <= ev_q_nxt;
      alert_r    <= alert_nxt;
      rd_index   <= rd_index_nxt;
      wr_strobe  <= wr_strobe_nxt;
      wr_index   <= wr_index_nxt;
      wr_data    <= wr_data_nxt;
    end
  end

  // Rising SCL: sample the bit the master or the slave placed on SDA.
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    shf_nxt      = shf_r;
    ack_nxt      = ack_r;
    rw_nxt       = rw_r;
    bidx_nxt     = bidx_r;
    tx_nxt       = tx_r;
    seen_nxt     = seen_r;
    sda_p_nxt    = bus.sda;
    ptr_nxt      = ptr_r;
    wdat_nxt     = wdat_r;
    ev_tgl_nxt   = ev_tgl_r;
    ev_dat_nxt   = ev_dat_r;
    lat_nxt      = lat_r;
    lat_addr_nxt = lat_addr_r;
    own          = lat_r ? lat_addr_r : sel_addr_r;
    byte8        = {shf_r, bus.sda};
    hit_own      = (shf_r == own);
    hit_ara      = alert_r && bus.sda && (shf_r == `ADDR_ALERT);
    if (stt_tgl_r != seen_r) begin
      seen_nxt = stt_tgl_r;
      st_nxt   = D_ADDR;
      cnt_nxt  = 4'h1;
      shf_nxt  = {6'h00, bus.sda};
    end else begin
      case (st_r)
        D_ADDR: begin
          if (cnt_r < 4'h7) begin
            shf_nxt = byte8[6:0];
            cnt_nxt = cnt_r + 4'h1;
          end else if (cnt_r == 4'h7) begin
            rw_nxt  = bus.sda;
            ack_nxt = hit_own || hit_ara;
            tx_nxt  = hit_own ? rd_data : {own, 1'b0};
            cnt_nxt = 4'h8;
            if (!lat_r && (shf_r == sel_addr_r)) begin
              lat_nxt      = 1'b1;
              lat_addr_nxt = sel_addr_r;
            end
          end else begin
            cnt_nxt  = 4'h0;
            bidx_nxt = 2'h0;
            st_nxt   = !ack_r ? D_SKIP : (rw_r ? D_RD : D_WR);
          end
        end
        D_WR: begin
          if (cnt_r < 4'h7) begin
            shf_nxt = byte8[6:0];
            cnt_nxt = cnt_r + 4'h1;
          end else if (cnt_r == 4'h7) begin
            ack_nxt = (bidx_r != 2'h2);
            cnt_nxt = 4'h8;
            if (bidx_r == 2'h0) begin
              ptr_nxt    = byte8;
              ev_dat_nxt = 1'b0;
              ev_tgl_nxt = ~ev_tgl_r;
            end else if (bidx_r == 2'h1) begin
              wdat_nxt   = byte8;
              ev_dat_nxt = 1'b1;
              ev_tgl_nxt = ~ev_tgl_r;
            end
            if (bidx_r != 2'h2) begin
              bidx_nxt = bidx_r + 2'h1;
            end
          end else begin
            cnt_nxt = 4'h0;
            st_nxt  = ack_r ? D_WR : D_SKIP;
          end
        end
        D_RD: begin
          // Losing arbitration on the alert answer stops our drive.
          if (cnt_r < 4'h8) begin
            tx_nxt  = {tx_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
            if (tx_r[7] && !bus.sda) begin
              st_nxt = D_SKIP;
            end
          end else begin
            st_nxt  = D_SKIP;
            cnt_nxt = 4'h0;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge bus.scl or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      st_r   <= D_IDLE;
      cnt_r  <= 4'h0;
      shf_r  <= 7'h00;
      ack_r  <= 1'b0;
      rw_r   <= 1'b0;
      bidx_r <= 2'h0;
      tx_r   <= 8'hFF;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      shf_r  <= shf_nxt;
      ack_r  <= ack_nxt;
      rw_r   <= rw_nxt;
      bidx_r <= bidx_nxt;
      tx_r   <= tx_nxt;
    end
  end

  // State that must survive a bus timeout.
  always_ff @(posedge bus.scl or negedge arst_n) begin
    if (!arst_n) begin
      seen_r     <= 1'b0;
      sda_p_r    <= 1'b1;
      ptr_r      <= `PTR_RESET;
      wdat_r     <= 8'h00;
      ev_tgl_r   <= 1'b0;
      ev_dat_r   <= 1'b0;
      lat_r      <= 1'b0;
      lat_addr_r <= `ADDR_DEFAULT;
    end else begin
      seen_r     <= seen_nxt;
      sda_p_r    <= sda_p_nxt;
      ptr_r      <= ptr_nxt;
      wdat_r     <= wdat_nxt;
      ev_tgl_r   <= ev_tgl_nxt;
      ev_dat_r   <= ev_dat_nxt;
      lat_r      <= lat_nxt;
      lat_addr_r <= lat_addr_nxt;
    end
  end

  // A stop leaves no SCL edge behind it, so it is marked on rising SDA.
  always_comb stp_tgl_nxt = bus.scl ? ~stp_tgl_r : stp_tgl_r;

  always_ff @(posedge bus.sda or negedge arst_n) begin
    if (!arst_n) begin
      stp_tgl_r <= 1'b0;
    end else begin
      stp_tgl_r <= stp_tgl_nxt;
    end
  end

  // Falling SCL: a start showed as SDA falling while SCL was high.
  always_comb begin
    stt_tgl_nxt = stt_tgl_r;
    stp_ack_nxt = stp_tgl_r;
    if ((sda_p_r && !bus.sda) || (stp_tgl_r != stp_ack_r)) begin
      stt_tgl_nxt = ~stt_tgl_r;
      oe_n_nxt    = 1'b1;
    end else begin
      oe_n_nxt = !((cnt_r == 4'h8) && ack_r && ((st_r == D_ADDR) || (st_r == D_WR))
                   || ((st_r == D_RD) && (cnt_r < 4'h8) && !tx_r[7]));
    end
  end

  always_ff @(negedge bus.scl or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= oe_n_nxt;
    end
  end

  always_ff @(negedge bus.scl or negedge arst_n) begin
    if (!arst_n) begin
      stt_tgl_r <= 1'b0;
      stp_ack_r <= 1'b0;
    end else begin
      stt_tgl_r <= stt_tgl_nxt;
      stp_ack_r <= stp_ack_nxt;
    end
  end
endmodule : smb_device

// *** verilog/smb_cfg.svh ***
// Constants of the bus slave, its strap addresses and the bus timing.
// Assumes a 100 MHz system clock on both ends.
`ifndef SMB_CFG_SVH
`define SMB_CFG_SVH
`define ADDR_DEFAULT 7'h2E
`define ADDR_SEL_LO  7'h2C
`define ADDR_SEL_HI  7'h2D
`define ADDR_ALERT   7'h0C
`define PTR_RESET    8'h00
`define CLK_MHZ      100
`define TMO_MS       35
`define TMO_CYCLES   (`TMO_MS * 1000 * `CLK_MHZ)
`define TMO_W        22
`define SCL_HALF     4'h4
`define SCL_QTR      4'h2
`define SCL_LAST     4'h7
`endif

// *** verilog/smb_pkg.sv ***
// Types shared by both ends of the management bus.
// Assumes nothing of its surroundings.
package smb_pkg;
  typedef enum logic [1:0] {K_SEND, K_WRITE, K_RECV, K_READ} kind_t;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_WR, D_RD, D_SKIP} dev_st_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} host_st_t;
endpackage : smb_pkg

// *** verilog/smb_if.sv ***
// Open-drain two-wire bus joining the host end and the device end.
// Assumes pull-ups: a line is low only while some end enables its driver.
`timescale 1ns/1ns
interface smb_if;
  logic scl_oe_n_host;
  logic scl_o_host;
  logic sda_oe_n_host;
  logic sda_o_host;
  logic sda_oe_n_dev;
  logic sda_o_dev;
  wire  scl;
  wire  sda;
  assign scl = scl_oe_n_host | scl_o_host;
  assign sda = (sda_oe_n_host | sda_o_host) & (sda_oe_n_dev | sda_o_dev);
  modport host (output scl_oe_n_host, output scl_o_host, output sda_oe_n_host,
                output sda_o_host, input scl, input sda);
  modport dev (output sda_oe_n_dev, output sda_o_dev, input scl, input sda);
endinterface : smb_if

// *** verilog/sync2.sv ***
// Two-flop synchroniser for one level.
// Assumes the destination clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module sync2 (
  input  wire logic clock,  // destination clock
  input  wire logic arst_n, // asynchronous reset
  input  wire logic d,      // level from another domain
  output logic      q       // synchronised level
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule : sync2

// *** verilog/smb_host.sv ***
// Host end: bus master running send, write, receive and read byte operations.
// Assumes one master on the bus; SCL is clock divided by eight.
`timescale 1ns/1ns
`include "smb_cfg.svh"
module smb_host
  import smb_pkg::*;
(
  input  wire logic       clock,     // system clock
  input  wire logic       arst_n,    // asynchronous reset
  smb_if.host             bus,       // bus pins
  input  wire logic       req_valid, // start an operation
  input  wire kind_t      req_kind,  // operation kind
  input  wire logic [6:0] req_addr,  // slave address
  input  wire logic [7:0] req_cmd,   // register index
  input  wire logic [7:0] req_data,  // data for write byte
  output logic            busy,      // operation in progress
  output logic            done,      // one-cycle end of operation
  output logic            nack,      // slave did not acknowledge
  output logic      [7:0] rdata      // byte read
);
  host_st_t   st_r, st_nxt;
  logic [3:0] ph_r, ph_nxt, bit_r, bit_nxt;
  logic [1:0] idx_r, idx_nxt;
  kind_t      kind_r, kind_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [7:0] cmd_r, cmd_nxt, dat_r, dat_nxt, sh_r, sh_nxt, rdata_nxt;
  logic       rx_r, rx_nxt, last_r, last_nxt;
  logic       scl_oe_n_r, scl_oe_n_nxt, sda_oe_n_r, sda_oe_n_nxt;
  logic       busy_nxt, done_nxt, nack_nxt, sda_s;
  logic [10:0] p;

  // Byte idx of an operation: {last, repeated start before, receive, byte}.
  function automatic logic [10:0] plan(kind_t k, logic [1:0] i, logic [6:0] a,
                                       logic [7:0] c, logic [7:0] d);
    logic [10:0] r;
    r = {3'b000, a, 1'b0};
    case (k)
      K_SEND:  if (i != 2'h0) r = {3'b100, c};
      K_WRITE: if (i == 2'h1) r = {3'b000, c}; else if (i != 2'h0) r = {3'b100, d};
      K_RECV:  if (i == 2'h0) r = {3'b000, a, 1'b1}; else r = {3'b101, 8'h00};
      K_READ: begin
        if (i == 2'h1) r = {3'b000, c};
        else if (i == 2'h2) r = {3'b010, a, 1'b1};
        else if (i == 2'h3) r = {3'b101, 8'h00};
      end
      default: r = {3'b100, 8'h00};
    endcase
    return r;
  endfunction : plan

  sync2 u_sda (.clock(clock), .arst_n(arst_n), .d(bus.sda), .q(sda_s));

  assign bus.scl_o_host    = 1'b0;
  assign bus.sda_o_host    = 1'b0;
  assign bus.scl_oe_n_host = scl_oe_n_r;
  assign bus.sda_oe_n_host = sda_oe_n_r;

  always_comb begin
    st_nxt = st_r;  ph_nxt = ph_r + 4'h1;  bit_nxt = bit_r;  idx_nxt = idx_r;
    kind_nxt = kind_r;  addr_nxt = addr_r;  cmd_nxt = cmd_r;  dat_nxt = dat_r;
    sh_nxt = sh_r;  rx_nxt = rx_r;  last_nxt = last_r;  rdata_nxt = rdata;
    busy_nxt = busy;  done_nxt = 1'b0;  nack_nxt = nack;
    p = plan(kind_r, idx_r, addr_r, cmd_r, dat_r);
    case (st_r)
      H_IDLE: begin
        ph_nxt = `SCL_HALF;
        if (req_valid) begin
          st_nxt = H_START;  busy_nxt = 1'b1;  nack_nxt = 1'b0;  idx_nxt = 2'h0;
          kind_nxt = req_kind;  addr_nxt = req_addr;  cmd_nxt = req_cmd;
          dat_nxt = req_data;
        end
      end
      H_START: if (ph_r == `SCL_LAST) begin
        st_nxt = H_BIT;  ph_nxt = 4'h0;  bit_nxt = 4'h0;
        sh_nxt = p[7:0];  rx_nxt = p[8];  last_nxt = p[10];
      end
      H_BIT: if (ph_r == `SCL_LAST) begin
        ph_nxt = 4'h0;
        if (bit_r != 4'h8) begin
          sh_nxt  = {sh_r[6:0], rx_r ? sda_s : 1'b0};
          bit_nxt = bit_r + 4'h1;
        end else if (!rx_r && sda_s) begin
          nack_nxt = 1'b1;  st_nxt = H_STOP;
        end else if (rx_r) begin
          rdata_nxt = sh_r;  st_nxt = H_STOP;
        end else if (last_r) begin
          st_nxt = H_STOP;
        end else begin
          idx_nxt = idx_r + 2'h1;
          p = plan(kind_r, idx_r + 2'h1, addr_r, cmd_r, dat_r);
          if (p[9]) begin
            st_nxt = H_START;
          end else begin
            bit_nxt = 4'h0;  sh_nxt = p[7:0];  rx_nxt = p[8];  last_nxt = p[10];
          end
        end
      end
      H_STOP: if (ph_r == `SCL_LAST) begin
        st_nxt = H_IDLE;  busy_nxt = 1'b0;  done_nxt = 1'b1;
      end
      default: st_nxt = H_IDLE;
    endcase
    // SDA moves one cycle after SCL falls; only a start or a stop moves it while SCL is high.
    scl_oe_n_nxt = (st_nxt == H_IDLE) || (ph_nxt >= `SCL_HALF);
    if (st_nxt == H_IDLE) begin
      sda_oe_n_nxt = 1'b1;
    end else if (ph_nxt == 4'h0) begin
      sda_oe_n_nxt = sda_oe_n_r;
    end else if (st_nxt == H_START) begin
      sda_oe_n_nxt = ph_nxt < (`SCL_HALF + `SCL_QTR);
    end else if (st_nxt == H_STOP) begin
      sda_oe_n_nxt = ph_nxt >= (`SCL_HALF + `SCL_QTR);
    end else begin
      sda_oe_n_nxt = !(!rx_nxt && (bit_nxt != 4'h8) && !sh_nxt[7]);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= H_IDLE;  ph_r <= 4'h0;  bit_r <= 4'h0;  idx_r <= 2'h0;
      kind_r <= K_SEND;  addr_r <= 7'h00;  cmd_r <= 8'h00;  dat_r <= 8'h00;
      sh_r <= 8'h00;  rx_r <= 1'b0;  last_r <= 1'b0;  rdata <= 8'h00;
      busy <= 1'b0;  done <= 1'b0;  nack <= 1'b0;
      scl_oe_n_r <= 1'b1;  sda_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;  ph_r <= ph_nxt;  bit_r <= bit_nxt;  idx_r <= idx_nxt;
      kind_r <= kind_nxt;  addr_r <= addr_nxt;  cmd_r <= cmd_nxt;  dat_r <= dat_nxt;
      sh_r <= sh_nxt;  rx_r <= rx_nxt;  last_r <= last_nxt;  rdata <= rdata_nxt;
      busy <= busy_nxt;  done <= done_nxt;  nack <= nack_nxt;
      scl_oe_n_r <= scl_oe_n_nxt;  sda_oe_n_r <= sda_oe_n_nxt;
    end
  end
endmodule : smb_host

// *** bench/smb_link_chk.sv ***
// Checker on the two-wire link between the host end and the device end.
// Assumes it sits beside the link interface and sees its resolved lines.
`timescale 1ns/1ns
module smb_link_chk (
  input wire logic clock,         // system clock
  input wire logic arst_n,        // asynchronous reset
  input wire logic sda_oe_n_host, // host pulls data low when 0
  input wire logic sda_oe_n_dev,  // device pulls data low when 0
  input wire logic scl,           // resolved clock line
  input wire logic sda            // resolved data line
);
  logic       scl_q_r, sda_q_r, rd_r, rd_nxt, rise, start, stop;
  logic [1:0] nb_r, nb_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] byte_r, byte_nxt;
  assign rise  = scl & ~scl_q_r;
  assign start = scl & scl_q_r & sda_q_r & ~sda;
  assign stop  = scl & scl_q_r & ~sda_q_r & sda;
  // Counting restarts at every start, so a repeated start opens a fresh address byte.
  always_comb begin
    cnt_nxt  = cnt_r;
    nb_nxt   = nb_r;
    byte_nxt = byte_r;
    rd_nxt   = rd_r;
    if (start) begin
      cnt_nxt = 4'h0;
      nb_nxt  = 2'h0;
    end else if (rise) begin
      cnt_nxt = (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h8 && nb_r != 2'h3) nb_nxt = nb_r + 2'h1;
      if (cnt_r != 4'h8) byte_nxt = {byte_r[6:0], sda};
      if (cnt_r == 4'h7 && nb_r == 2'h0) rd_nxt = sda;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      cnt_r   <= 4'h0;
      nb_r    <= 2'h3;
      byte_r  <= 8'h00;
      rd_r    <= 1'b0;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      cnt_r   <= cnt_nxt;
      nb_r    <= nb_nxt;
      byte_r  <= byte_nxt;
      rd_r    <= rd_nxt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_low4;
    !scl [*4] ##1 scl;
  endsequence
  sequence s_idle4;
    (scl && sda) [*4];
  endsequence
  AST_DEV_STABLE: assert property (scl && scl_q_r |-> $stable(sda_oe_n_dev))
    else $error("device data driver moved while clock high");
  AST_SCL_LOW: assert property ($fell(scl) |-> s_low4)
    else $error("clock low phase not four cycles");
  AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*4])
    else $error("clock high phase shorter than four cycles");
  AST_ADDR_ACK: assert property (rise && nb_r == 2'h0 && cnt_r == 4'h8 && !sda_oe_n_dev
    |-> byte_r[7:1] inside {7'h2C, 7'h2D, 7'h2E, 7'h0C})
    else $error("device acknowledged a foreign address");
  AST_ADDR_FREE: assert property (rise && nb_r == 2'h0 && cnt_r != 4'h8 |-> sda_oe_n_dev)
    else $error("device drove data during address bits");
  AST_READ_END: assert property (rise && nb_r == 2'h1 && rd_r && cnt_r == 4'h8
    |-> sda_oe_n_dev && sda)
    else $error("read byte not closed by released data line");
  AST_WR_FREE: assert property (rise && nb_r inside {2'h1, 2'h2} && !rd_r && cnt_r != 4'h8
    |-> sda_oe_n_dev)
    else $error("device drove data during written bits");
  AST_WR_ACK: assert property (rise && nb_r inside {2'h1, 2'h2} && !rd_r && cnt_r == 4'h8
    |-> !sda_oe_n_dev && sda_oe_n_host)
    else $error("written byte not acknowledged by device");
  AST_WR_STOP: assert property (rise && nb_r == 2'h2 && !rd_r && cnt_r == 4'h8
    |-> ##[1:16] stop)
    else $error("two-byte write not ended by stop");
  AST_STOP_IDLE: assert property (stop |-> s_idle4)
    else $error("lines not idle after stop");
endmodule : smb_link_chk

// *** bench/test_smbus_slave_register_access.sv ***
// Self-checking bench: host end and device end joined on one link.
// Assumes both ends, the link interface and the checker are compiled first.
`timescale 1ns/1ns
module test_smbus_slave_register_access;
  import smb_pkg::*;
  typedef struct packed {logic rd; logic nk; logic [7:0] dt;} note_t;
  logic        clock = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
  logic        ena = 1'b1, sel = 1'b0, tmo_off = 1'b0, alert = 1'b0;
  kind_t       req_kind = K_SEND;
  logic [6:0]  req_addr = 7'h00, own;
  logic [7:0]  req_cmd = 8'h00, req_data = 8'h00, c, d, ptr;
  logic [7:0]  rd_data, rd_index, wr_index, wr_data, rdata;
  logic        busy, done, nack, wr_strobe;
  logic [7:0]  regs [256];
  logic [7:0]  mdl [256];
  note_t       n;
  note_t       rq [$];
  logic [15:0] wq [$];
  int          error_cnt = 0, num_checks = 0, seed = 41;
  smb_if bus_if ();
  smb_host smb_host_inst (.clock(clock), .arst_n(arst_n), .bus(bus_if.host),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr), .req_cmd(req_cmd),
    .req_data(req_data), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
  smb_device #(.TIMEOUT_CYCLES(22'h0000C8)) smb_device_inst (.clock(clock), .arst_n(arst_n),
    .bus(bus_if.dev), .address_strap_enable(ena), .addr_select_strap(sel),
    .bus_timeout_disable(tmo_off), .alert_active(alert), .rd_data(rd_data),
    .rd_index(rd_index), .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
  smb_link_chk smb_link_chk_inst (.clock(clock), .arst_n(arst_n),
    .sda_oe_n_host(bus_if.sda_oe_n_host), .sda_oe_n_dev(bus_if.sda_oe_n_dev),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // The register file answers at once and holds still, as the device samples it unsynchronised.
  assign rd_data = regs[rd_index];
  always @(posedge clock) if (wr_strobe === 1'b1) regs[wr_index] <= wr_data;
  initial forever #5 clock = ~clock;
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic tend(input int t);
    $display("test %0d done", t);
  endtask : tend
  task automatic rst(input logic e, s);
    @(posedge clock);
    arst_n <= 1'b0;
    ena    <= e;
    sel    <= s;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
    ptr = 8'h00;
    own = e ? 7'h2E : (s ? 7'h2D : 7'h2C);
  endtask : rst
  task automatic op(input kind_t k, input logic [6:0] a, input logic [7:0] cm, dt,
                    input logic nk);
    int w;
    w = 0;
    if (k != K_RECV && !nk) ptr = cm;
    if (k == K_WRITE && !nk) begin
      mdl[cm] = dt;
      wq.push_back({cm, dt});
    end
    rq.push_back('{(k == K_RECV || k == K_READ), nk, (a == 7'h0C) ? {own, 1'b0} : mdl[ptr]});
    @(posedge clock);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_addr  <= a;
    req_cmd   <= cm;
    req_data  <= dt;
    @(posedge clock);
    req_valid <= 1'b0;
    while (done !== 1'b1 && w < 3000) begin
      @(negedge clock);
      w++;
    end
    if (w == 3000) error_cnt++;
  endtask : op
  always @(negedge clock) begin
    if (done === 1'b1) begin
      n = rq.pop_front();
      chk(16'(nack), 16'(n.nk));
      if (n.rd && !n.nk) chk(16'(rdata), 16'(n.dt));
    end
    if (wr_strobe === 1'b1) chk({wr_index, wr_data}, wq.pop_front());
  end
  // Twenty-six operations of at most some three hundred cycles each; allow a wide margin.
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($random(seed));
      mdl[i]  = regs[i];
    end
    rst(1'b1, 1'b0);
    op(K_RECV, 7'h2E, 8'h00, 8'h00, 1'b0);
    op(K_RECV, 7'h2E, 8'h00, 8'h00, 1'b0);
    tend(1);
    repeat (4) begin
      c = 8'($random(seed));
      d = 8'($random(seed));
      op(K_WRITE, 7'h2E, c, d, 1'b0);
      op(K_SEND, 7'h2E, ~c, 8'h00, 1'b0);
      op(K_RECV, 7'h2E, 8'h00, 8'h00, 1'b0);
      op(K_READ, 7'h2E, c, 8'h00, 1'b0);
    end
    tend(2);
    @(posedge clock) tmo_off <= 1'b1;
    op(K_WRITE, 7'h2D, 8'h11, 8'hA5, 1'b1);
    op(K_SEND, 7'h0C, 8'h00, 8'h00, 1'b1);
    @(posedge clock) alert <= 1'b1;
    op(K_RECV, 7'h0C, 8'h00, 8'h00, 1'b0);
    @(posedge clock) alert <= 1'b0;
    tend(3);
    rst(1'b0, 1'b0);
    @(posedge clock) sel <= 1'b1;
    own = 7'h2D;
    op(K_SEND, 7'h2D, 8'h22, 8'h00, 1'b0);
    @(posedge clock) sel <= 1'b0;
    op(K_SEND, 7'h2C, 8'h23, 8'h00, 1'b1);
    op(K_RECV, 7'h2D, 8'h00, 8'h00, 1'b0);
    rst(1'b0, 1'b0);
    op(K_WRITE, 7'h2C, 8'h30, 8'h3C, 1'b0);
    op(K_RECV, 7'h2E, 8'h00, 8'h00, 1'b1);
    tend(4);
    repeat (20) @(posedge clock);
    chk(16'(rq.size() + wq.size()), 16'h0000);
    test_done();
  end
endmodule : test_smbus_slave_register_access
